// >>> logic/lrt_map.svh
// Offsets, bit positions, reset values and timing counts of the remote state and test control block.
`ifndef LRT_MAP_SVH
`define LRT_MAP_SVH

// ----------------------------------------------------------------------------
// Status word layouts
// ----------------------------------------------------------------------------
`define LRT_FAULT_CHAN_LSB  0
`define LRT_FAULT_CHAN_MSB  3
`define LRT_FAULT_OPER_BIT  4
`define LRT_FAULT_CMD_BIT   5
`define LRT_TRIP_POWER_BIT  0
`define LRT_TRIP_TEMP_BIT   1
`define LRT_TRIP_VOLT_BIT   2
`define LRT_TRIP_CURR_BIT   3
`define LRT_FAULT_RESET     8'h00
`define LRT_TRIP_RESET      8'h00

// ----------------------------------------------------------------------------
// Parameter slots of the test parameter table
// ----------------------------------------------------------------------------
`define LRT_PAR_START       3'h0
`define LRT_PAR_STEP        3'h1
`define LRT_PAR_STOP        3'h2
`define LRT_PAR_VTH         3'h3
`define LRT_PAR_LOW_LIM     3'h4
`define LRT_PAR_HIGH_LIM    3'h5
`define LRT_PAR_LOW_LEVEL   3'h6
`define LRT_PAR_SHORT_MS    3'h7

// ----------------------------------------------------------------------------
// Settings memory and readings
// ----------------------------------------------------------------------------
`define LRT_SLOT_MIN        16'h0001
`define LRT_SLOT_MAX        16'h0096
`define LRT_SLOTS           150
`define LRT_READING_MAX     20'h1869F

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LRT_CLK_NS          50
`define LRT_MS_NS           1000000
`define LRT_MS_CYC          (`LRT_MS_NS / `LRT_CLK_NS)

`endif

// >>> logic/lrt_pkg.sv
// Types shared by the remote state and test control block.
`default_nettype none
package lrt_pkg;

	// Decoded remote commands; any other code is a command error.
	typedef enum logic [4:0] {
		LRT_CMD_LEVEL_SET  = 5'h01,
		LRT_CMD_LEVEL_Q    = 5'h02,
		LRT_CMD_AFREQ_SET  = 5'h03,
		LRT_CMD_AFREQ_Q    = 5'h04,
		LRT_CMD_CLR_FAULTS = 5'h05,
		LRT_CMD_FAULT_Q    = 5'h06,
		LRT_CMD_TRIP_Q     = 5'h07,
		LRT_CMD_FAIL_Q     = 5'h08,
		LRT_CMD_FAILEN_SET = 5'h09,
		LRT_CMD_TSEL_SET   = 5'h0A,
		LRT_CMD_START      = 5'h0B,
		LRT_CMD_STOP       = 5'h0C,
		LRT_CMD_TESTING_Q  = 5'h0D,
		LRT_CMD_SYNC_SET   = 5'h0E,
		LRT_CMD_SYNC_Q     = 5'h0F,
		LRT_CMD_RECALL     = 5'h10,
		LRT_CMD_STORE      = 5'h11,
		LRT_CMD_REMOTE     = 5'h12,
		LRT_CMD_LOCAL      = 5'h13,
		LRT_CMD_MEAS_I     = 5'h14,
		LRT_CMD_MEAS_V     = 5'h15,
		LRT_CMD_MEAS_P     = 5'h16,
		LRT_CMD_MEAS_VAR   = 5'h17,
		LRT_CMD_MEAS_VA    = 5'h18,
		LRT_CMD_PARAM_SET  = 5'h19,
		LRT_CMD_PARAM_Q    = 5'h1A,
		LRT_CMD_RESULT_Q   = 5'h1B,
		LRT_CMD_MODE_SET   = 5'h1C
	} lrt_cmd_e;

	typedef enum logic [1:0] {
		LRT_TEST_NONE  = 2'h0,
		LRT_TEST_OCP   = 2'h1,
		LRT_TEST_OPP   = 2'h2,
		LRT_TEST_SHORT = 2'h3
	} lrt_test_e;

	typedef enum logic [1:0] {
		LRT_MODE_CC = 2'h0,
		LRT_MODE_CR = 2'h1,
		LRT_MODE_CV = 2'h2,
		LRT_MODE_CP = 2'h3
	} lrt_mode_e;

	// Gray order along idle, ramp, short.
	typedef enum logic [1:0] {
		LRT_ST_IDLE  = 2'b00,
		LRT_ST_RAMP  = 2'b01,
		LRT_ST_SHORT = 2'b11
	} lrt_state_e;

endpackage : lrt_pkg
`default_nettype wire

// >>> logic/lrt_core.sv
// Remote command interpreter: state, system, measurement and test-mode control of the load.
//
// Overview of operation
// [R01] Level A/B select command; level query reports the selected level.
// [R02] Low level value means current, resistance, voltage or power by mode.
// [R03] Automatic frequency writable on/off; query returns 0 off, 1 on.
// [R04] Clear-faults command zeroes protection flags and fault summary.
// [R05] Fault summary: bits 0-3 channel, bit 4 operation, bit 5 command error.
// [R06] Protection flags: bit0 power, bit1 temperature, bit2 voltage, bit3 current.
// [R07] Protection query reports flags weighted: 1 power, 2 temperature, 4 voltage, 8 current.
// [R08] Pass/fail query returns 1 when fail indicator lit, else 0.
// [R09] Fail-check enable off skips pass/fail evaluation; on performs it.
// [R10] Start runs the selected test with its configured parameters.
// [R11] Stop terminates any running test.
// [R12] Test-active query returns 1 while testing, 0 once ended.
// [R13] Sync enable writable on/off; query returns 1 on, 0 off.
// [R14] Load command restores whole configuration from slot 1 to 150.
// [R15] Save command writes present configuration into slot 1 to 150.
// [R16] Remote and local commands switch control state, link sources only.
// [R17] Measurement queries return five-digit meter readings.
// [R18] Over-current test uses configured ramp and limits; fail reads 0 pass, 1 fail.
// [R19] Over-power test reports reached power level when queried afterwards.
// [R20] Short test runs for the set duration in milliseconds after start.
// [R21] Short duration zero keeps the short applied until stopped.
// [R22] Unknown or malformed command sets command-error bit, changes nothing else.
// [R23] Stop with no test active has no effect.
`timescale 1ns/1ps
`default_nettype none
`include "lrt_map.svh"

module lrt_core #(
	parameter int unsigned MS_CYCLES = `LRT_MS_CYC
) (
	input  wire logic        clk,              // 20 MHz clock
	input  wire logic        resetn,           // asynchronous reset, active low
	input  wire logic        cmd_valid,        // one-cycle strobe of a parsed command
	input  wire logic [4:0]  cmd_code,         // command code
	input  wire logic [2:0]  cmd_idx,          // parameter slot for parameter commands
	input  wire logic [15:0] cmd_arg,          // command argument
	input  wire logic        cmd_from_link,    // command came over USB, LAN or serial
	input  wire logic [3:0]  trip_pin,         // power, temperature, voltage, current trips
	input  wire logic [3:0]  chan_err_pin,     // channel error lines
	input  wire logic        vth_cross_pin,    // load voltage fell below threshold
	input  wire logic [16:0] meter_current,    // current meter
	input  wire logic [16:0] meter_voltage,    // voltage meter
	input  wire logic [16:0] meter_power,      // power meter
	input  wire logic [16:0] meter_reactive,   // reactive power meter
	input  wire logic [16:0] meter_apparent,   // apparent power meter
	output logic             rsp_valid,        // one-cycle strobe of a query answer
	output logic [19:0]      rsp_data,         // query answer
	output logic             level_select,     // 1 selects level B
	output logic [1:0]       load_mode,        // regulation mode of the low level
	output logic [15:0]      low_level,        // low level value
	output logic             automatic_frequency, // frequency automation on
	output logic             sync_signal_enable,  // sync output enabled
	output logic             remote_mode,      // remote control state
	output logic [15:0]      threshold_voltage, // ramp test voltage threshold
	output logic [15:0]      load_setpoint,    // ramp setpoint driven to the sink
	output logic             short_on,         // short applied
	output logic             testing,          // test in progress
	output logic             fail_indicator    // fail lamp
);

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [8:0] pin_meta_ff;
	logic [8:0] pin_sync_ff;
	logic [3:0] trip_s;
	logic [3:0] chan_err_s;
	logic       vth_cross_s;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_meta_ff <= 9'h000;
			pin_sync_ff <= 9'h000;
		end
		else
		begin
			pin_meta_ff <= {vth_cross_pin, chan_err_pin, trip_pin};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	assign trip_s      = pin_sync_ff[3:0];
	assign chan_err_s  = pin_sync_ff[7:4];
	assign vth_cross_s = pin_sync_ff[8];

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	logic       cmd_known;
	logic       slot_bad;
	logic       cmd_bad;
	logic [7:0] slot_idx;
	logic       is_start;
	logic       is_stop;

	always_comb
	begin
		cmd_known = 1'b0;
		if ((cmd_code >= 5'h01) && (cmd_code <= 5'h1C))
			cmd_known = 1'b1;
	end

	assign slot_bad = ((cmd_code == lrt_pkg::LRT_CMD_RECALL) || (cmd_code == lrt_pkg::LRT_CMD_STORE)) &&
		((cmd_arg < `LRT_SLOT_MIN) || (cmd_arg > `LRT_SLOT_MAX));
	// Remote and local are only meaningful from a link source.
	assign cmd_bad  = cmd_valid && (!cmd_known || slot_bad ||
		(((cmd_code == lrt_pkg::LRT_CMD_REMOTE) || (cmd_code == lrt_pkg::LRT_CMD_LOCAL)) && !cmd_from_link)); // R22 R16
	assign slot_idx = 8'(cmd_arg - 16'h0001);
	assign is_start = cmd_valid && !cmd_bad && (cmd_code == lrt_pkg::LRT_CMD_START);
	assign is_stop  = cmd_valid && !cmd_bad && (cmd_code == lrt_pkg::LRT_CMD_STOP);

	// ------------------------------------------------------------------------
	// Configuration and settings memory
	// ------------------------------------------------------------------------
	logic              level_b_ff;
	logic              afreq_ff;
	logic              sync_ff;
	logic              fail_en_ff;
	logic              remote_ff;
	lrt_pkg::lrt_test_e tsel_ff;
	lrt_pkg::lrt_mode_e mode_ff;
	logic [7:0][15:0]  param_ff;
	logic [135:0]      slot_mem [0:`LRT_SLOTS-1];
	logic [135:0]      slot_word;
	logic              cmd_ok;

	assign cmd_ok    = cmd_valid && !cmd_bad;
	assign slot_word = slot_mem[slot_idx];

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			level_b_ff <= 1'b0;
			afreq_ff   <= 1'b0;
			sync_ff    <= 1'b0;
			fail_en_ff <= 1'b0;
			remote_ff  <= 1'b0;
			tsel_ff    <= lrt_pkg::LRT_TEST_NONE;
			mode_ff    <= lrt_pkg::LRT_MODE_CC;
			param_ff   <= '0;
		end
		else if (cmd_ok)
		begin
			case (cmd_code)
				lrt_pkg::LRT_CMD_LEVEL_SET:  level_b_ff <= cmd_arg[0]; // R01
				lrt_pkg::LRT_CMD_AFREQ_SET:  afreq_ff <= cmd_arg[0]; // R03
				lrt_pkg::LRT_CMD_SYNC_SET:   sync_ff <= cmd_arg[0]; // R13
				lrt_pkg::LRT_CMD_FAILEN_SET: fail_en_ff <= cmd_arg[0]; // R09
				lrt_pkg::LRT_CMD_TSEL_SET:   tsel_ff <= lrt_pkg::lrt_test_e'(cmd_arg[1:0]);
				lrt_pkg::LRT_CMD_MODE_SET:   mode_ff <= lrt_pkg::lrt_mode_e'(cmd_arg[1:0]); // R02
				lrt_pkg::LRT_CMD_PARAM_SET:  param_ff[cmd_idx] <= cmd_arg; // R18 R19 R20
				lrt_pkg::LRT_CMD_REMOTE:     remote_ff <= 1'b1; // R16
				lrt_pkg::LRT_CMD_LOCAL:      remote_ff <= 1'b0; // R16
				lrt_pkg::LRT_CMD_RECALL:
				begin
					mode_ff    <= lrt_pkg::lrt_mode_e'(slot_word[135:134]); // R14
					level_b_ff <= slot_word[133];
					afreq_ff   <= slot_word[132];
					sync_ff    <= slot_word[131];
					fail_en_ff <= slot_word[130];
					tsel_ff    <= lrt_pkg::lrt_test_e'(slot_word[129:128]);
					param_ff   <= slot_word[127:0]; // R14
				end
				default: ;
			endcase
		end
	end

	// The memory has no reset; a slot never saved reads undefined on recall.
	always_ff @(posedge clk)
	begin
		if (cmd_ok && (cmd_code == lrt_pkg::LRT_CMD_STORE))
			slot_mem[slot_idx] <= {mode_ff, level_b_ff, afreq_ff, sync_ff, fail_en_ff, tsel_ff, param_ff}; // R15
	end

	// ------------------------------------------------------------------------
	// Test sequencer
	// ------------------------------------------------------------------------
	lrt_pkg::lrt_state_e state_ff;
	logic [14:0]         tick_cnt_ff;
	logic                tick;
	logic [15:0]         ms_cnt_ff;
	logic [15:0]         setpoint_ff;
	logic [15:0]         result_ff;
	logic                fail_ff;
	logic [16:0]         nxt_setpoint;
	logic                ramp_end;
	logic                start_ok;

	assign tick         = (tick_cnt_ff == 15'(MS_CYCLES - 1));
	assign nxt_setpoint = {1'b0, setpoint_ff} + {1'b0, param_ff[`LRT_PAR_STEP]};
	assign ramp_end     = (state_ff == lrt_pkg::LRT_ST_RAMP) && tick &&
		(vth_cross_s || (nxt_setpoint > {1'b0, param_ff[`LRT_PAR_STOP]}));
	assign start_ok     = is_start && (state_ff == lrt_pkg::LRT_ST_IDLE) && (tsel_ff != lrt_pkg::LRT_TEST_NONE);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tick_cnt_ff <= 15'h0000;
		else if (start_ok || tick || (state_ff == lrt_pkg::LRT_ST_IDLE))
			tick_cnt_ff <= 15'h0000;
		else
			tick_cnt_ff <= tick_cnt_ff + 15'h0001;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff    <= lrt_pkg::LRT_ST_IDLE;
			setpoint_ff <= 16'h0000;
			ms_cnt_ff   <= 16'h0000;
		end
		else if (is_stop)
			state_ff <= lrt_pkg::LRT_ST_IDLE; // R11 R23
		else
		begin
			case (state_ff)
				lrt_pkg::LRT_ST_IDLE:
				begin
					if (start_ok) // R10
					begin
						setpoint_ff <= param_ff[`LRT_PAR_START];
						ms_cnt_ff   <= 16'h0000;
						state_ff    <= (tsel_ff == lrt_pkg::LRT_TEST_SHORT) ? lrt_pkg::LRT_ST_SHORT
							: lrt_pkg::LRT_ST_RAMP; // R20
					end
				end
				lrt_pkg::LRT_ST_RAMP:
				begin
					if (ramp_end)
						state_ff <= lrt_pkg::LRT_ST_IDLE;
					else if (tick)
						setpoint_ff <= nxt_setpoint[15:0]; // R18 R19
				end
				lrt_pkg::LRT_ST_SHORT:
				begin
					if (tick)
					begin
						ms_cnt_ff <= ms_cnt_ff + 16'h0001;
						// A zero duration never matches, so the short holds until stop.
						if ((param_ff[`LRT_PAR_SHORT_MS] != 16'h0000) &&
							(ms_cnt_ff == param_ff[`LRT_PAR_SHORT_MS] - 16'h0001)) // R20 R21
							state_ff <= lrt_pkg::LRT_ST_IDLE;
					end
				end
				default: state_ff <= lrt_pkg::LRT_ST_IDLE;
			endcase
		end
	end

	// Result and pass/fail evaluation.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			result_ff <= 16'h0000;
			fail_ff   <= 1'b0;
		end
		else if (start_ok)
			fail_ff <= 1'b0;
		else if (ramp_end && !is_stop)
		begin
			result_ff <= setpoint_ff; // R19
			if (fail_en_ff) // R09
				fail_ff <= (setpoint_ff < param_ff[`LRT_PAR_LOW_LIM]) ||
					(setpoint_ff > param_ff[`LRT_PAR_HIGH_LIM]); // R18
		end
	end

	// ------------------------------------------------------------------------
	// Fault summary and protection flags
	// ------------------------------------------------------------------------
	logic [7:0] fault_summary_ff;
	logic [7:0] safeguard_trip_flags_ff;
	logic       clr_faults;
	logic       oper_err;

	assign clr_faults = cmd_ok && (cmd_code == lrt_pkg::LRT_CMD_CLR_FAULTS);
	assign oper_err   = is_start && !start_ok;

	// New events in the clearing cycle survive the clear.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			safeguard_trip_flags_ff <= `LRT_TRIP_RESET;
		else
			safeguard_trip_flags_ff <= (clr_faults ? 8'h00 : safeguard_trip_flags_ff) | {4'h0, trip_s}; // R04 R06
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fault_summary_ff <= `LRT_FAULT_RESET;
		else
		begin
			fault_summary_ff <= (clr_faults ? 8'h00 : fault_summary_ff) | // R04
				{2'b00, cmd_bad, oper_err, chan_err_s}; // R05 R22
		end
	end

	// ------------------------------------------------------------------------
	// Query answers
	// ------------------------------------------------------------------------
	function automatic logic [19:0] five_digit(input logic [16:0] v);
		five_digit = ({3'h0, v} > `LRT_READING_MAX) ? `LRT_READING_MAX : {3'h0, v};
	endfunction : five_digit

	logic        rsp_valid_ff;
	logic [19:0] rsp_data_ff;
	logic [19:0] nxt_rsp_data;
	logic        nxt_rsp_valid;

	always_comb
	begin
		nxt_rsp_valid = cmd_ok;
		nxt_rsp_data  = 20'h00000;
		case (cmd_code)
			lrt_pkg::LRT_CMD_LEVEL_Q:   nxt_rsp_data = {19'h0, level_b_ff}; // R01
			lrt_pkg::LRT_CMD_AFREQ_Q:   nxt_rsp_data = {19'h0, afreq_ff}; // R03
			lrt_pkg::LRT_CMD_FAULT_Q:   nxt_rsp_data = {12'h0, fault_summary_ff}; // R05
			lrt_pkg::LRT_CMD_TRIP_Q:    nxt_rsp_data = {12'h0, safeguard_trip_flags_ff}; // R07
			lrt_pkg::LRT_CMD_FAIL_Q:    nxt_rsp_data = {19'h0, fail_ff}; // R08
			lrt_pkg::LRT_CMD_TESTING_Q: nxt_rsp_data = {19'h0, (state_ff != lrt_pkg::LRT_ST_IDLE)}; // R12
			lrt_pkg::LRT_CMD_SYNC_Q:    nxt_rsp_data = {19'h0, sync_ff}; // R13
			lrt_pkg::LRT_CMD_MEAS_I:    nxt_rsp_data = five_digit(meter_current); // R17
			lrt_pkg::LRT_CMD_MEAS_V:    nxt_rsp_data = five_digit(meter_voltage); // R17
			lrt_pkg::LRT_CMD_MEAS_P:    nxt_rsp_data = five_digit(meter_power); // R17
			lrt_pkg::LRT_CMD_MEAS_VAR:  nxt_rsp_data = five_digit(meter_reactive); // R17
			lrt_pkg::LRT_CMD_MEAS_VA:   nxt_rsp_data = five_digit(meter_apparent); // R17
			lrt_pkg::LRT_CMD_PARAM_Q:   nxt_rsp_data = {4'h0, param_ff[cmd_idx]};
			lrt_pkg::LRT_CMD_RESULT_Q:  nxt_rsp_data = {4'h0, result_ff}; // R19
			default:                    nxt_rsp_valid = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= 20'h00000;
		end
		else
		begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff  <= nxt_rsp_data;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign rsp_valid           = rsp_valid_ff;
	assign rsp_data            = rsp_data_ff;
	assign level_select        = level_b_ff;
	assign load_mode           = mode_ff;
	assign low_level           = param_ff[`LRT_PAR_LOW_LEVEL];
	assign automatic_frequency = afreq_ff;
	assign sync_signal_enable  = sync_ff;
	assign remote_mode         = remote_ff;
	assign threshold_voltage   = param_ff[`LRT_PAR_VTH];
	assign load_setpoint       = setpoint_ff;
	// The Gray state code lets both status outputs come straight from state bits.
	assign short_on            = state_ff[1];
	assign testing             = state_ff[0];
	assign fail_indicator      = fail_ff;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	AST_LEVEL_QUERY: assert property (@(posedge clk) disable iff (!resetn) // R01
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_LEVEL_Q) |=> rsp_valid && rsp_data == {19'h0, $past(level_b_ff)})
		else $error("level query answer wrong");

	AST_AFREQ_SET: assert property (@(posedge clk) disable iff (!resetn) // R03
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_AFREQ_SET) |=> automatic_frequency == $past(cmd_arg[0]))
		else $error("frequency setting not taken");

	AST_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // R04
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_CLR_FAULTS && trip_s == 4'h0 && chan_err_s == 4'h0)
		|=> fault_summary_ff == 8'h00 && safeguard_trip_flags_ff == 8'h00)
		else $error("clear did not zero flags");

	AST_TRIP_STICKY: assert property (@(posedge clk) disable iff (!resetn) // R06
		trip_s[`LRT_TRIP_CURR_BIT] |=> safeguard_trip_flags_ff[`LRT_TRIP_CURR_BIT] ##1
		(safeguard_trip_flags_ff[`LRT_TRIP_CURR_BIT] || $past(clr_faults)))
		else $error("current trip flag lost");

	AST_CMD_ERROR: assert property (@(posedge clk) disable iff (!resetn) // R22
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_RECALL && (cmd_arg == 16'h0000 || cmd_arg > `LRT_SLOT_MAX))
		|=> fault_summary_ff[`LRT_FAULT_CMD_BIT] && $stable(level_b_ff) && !rsp_valid)
		else $error("bad slot not flagged");

	AST_START: assert property (@(posedge clk) disable iff (!resetn) // R10
		start_ok |=> testing && (short_on == ($past(tsel_ff) == lrt_pkg::LRT_TEST_SHORT)))
		else $error("start did not run selected test");

	AST_STOP: assert property (@(posedge clk) disable iff (!resetn) // R11
		is_stop |=> !testing ##1 !short_on)
		else $error("stop did not end test");

	AST_SHORT_FOREVER: assert property (@(posedge clk) disable iff (!resetn) // R21
		(short_on && param_ff[`LRT_PAR_SHORT_MS] == 16'h0000 && !is_stop) |=> short_on)
		else $error("unlimited short ended");

	AST_NO_EVAL: assert property (@(posedge clk) disable iff (!resetn) // R09
		(ramp_end && !fail_en_ff && !is_stop) |=> $stable(fail_indicator))
		else $error("fail evaluated while disabled");

	AST_MEAS: assert property (@(posedge clk) disable iff (!resetn) // R17
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_MEAS_V) |=> rsp_valid && rsp_data <= `LRT_READING_MAX &&
		(($past(meter_voltage) > 17'h1869F) || rsp_data == {3'h0, $past(meter_voltage)}))
		else $error("voltage reading wrong");

	AST_REMOTE: assert property (@(posedge clk) disable iff (!resetn) // R16
		(cmd_valid && cmd_code == lrt_pkg::LRT_CMD_REMOTE && !cmd_from_link) |=> remote_mode == $past(remote_mode))
		else $error("remote taken from non-link source");

endmodule : lrt_core
`default_nettype wire

// >>> verif/lrt_host_model.sv
// Host-side model that sends remote command words to the load.
`timescale 1ns/1ps
`default_nettype none
module lrt_host_model (
	input  wire logic        clk,          // command clock
	output logic             cmd_valid,    // command strobe
	output logic [4:0]       cmd_code,     // command code
	output logic [2:0]       cmd_idx,      // parameter slot
	output logic [15:0]      cmd_arg,      // argument
	output logic             cmd_from_link // command came over the link
);
	// ----------------------------------------------------------------
	// Command issue
	// ----------------------------------------------------------------
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 5'h00;
		cmd_idx = 3'h0;
		cmd_arg = 16'h0000;
		cmd_from_link = 1'b0;
	end

	// Released lines carry the inverse, so a stale word can never pass for a live one.
	task send(input logic [4:0] c, input logic [2:0] i, input logic [15:0] a, input logic l);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_idx = i;
		cmd_arg = a;
		cmd_from_link = l;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_idx = ~i;
		cmd_arg = ~a;
		cmd_from_link = ~l;
	endtask : send
endmodule : lrt_host_model
`default_nettype wire

// >>> verif/load_remote_state_test_control_test.sv
// Self-checking bench of the remote state and test control block.
`timescale 1ns/1ps
`default_nettype none
module load_remote_state_test_control_test;
	logic        clk, resetn, cmd_valid, cmd_from_link, vth_cross_pin, rsp_valid, level_select;
	logic        automatic_frequency, sync_signal_enable, remote_mode, short_on, testing, fail_indicator;
	logic [4:0]  cmd_code;
	logic [2:0]  cmd_idx;
	logic [15:0] cmd_arg;
	logic [3:0]  trip_pin, chan_err_pin;
	logic [16:0] meter [5];
	logic [19:0] rsp_data;
	logic [15:0] low_level, threshold_voltage, load_setpoint;
	logic [1:0]  load_mode;
	logic [31:0] seed;
	int          n_errors, checks_done;

	lrt_core #(.MS_CYCLES(4)) dut_u (.clk, .resetn, .cmd_valid, .cmd_code, .cmd_idx, .cmd_arg, .cmd_from_link,
		.trip_pin, .chan_err_pin, .vth_cross_pin, .meter_current(meter[0]), .meter_voltage(meter[1]),
		.meter_power(meter[2]), .meter_reactive(meter[3]), .meter_apparent(meter[4]), .rsp_valid, .rsp_data,
		.level_select, .load_mode, .low_level, .automatic_frequency, .sync_signal_enable, .remote_mode,
		.threshold_voltage, .load_setpoint, .short_on, .testing, .fail_indicator);
	lrt_host_model host_u (.clk, .cmd_valid, .cmd_code, .cmd_idx, .cmd_arg, .cmd_from_link);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task chk(input string what, input logic [19:0] e, input logic [19:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task results();
		$display("Checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task cmd(input logic [4:0] c, input logic [15:0] a);
		host_u.send(c, 3'h0, a, 1'b1);
	endtask : cmd

	task par(input logic [2:0] i, input logic [15:0] a);
		host_u.send(lrt_pkg::LRT_CMD_PARAM_SET, i, a, 1'b1);
	endtask : par

	task qc(input logic [4:0] c, input logic [19:0] e);
		host_u.send(c, 3'h0, 16'h0000, 1'b1);
		chk("rsp_valid", 20'h00001, {19'h0, rsp_valid});
		chk("rsp_data", e, rsp_data);
	endtask : qc

	// Counts the cycles a started test stays active; a test that never ends closes the run.
	task run(output int n);
		cmd(lrt_pkg::LRT_CMD_START, 16'h0000);
		n = int'(testing === 1'b1);
		for (int k = 0; k < 400 && (n == 0 || testing === 1'b1); k++)
		begin
			@(negedge clk);
			n += (testing === 1'b1);
		end
		if (testing !== 1'b0)
		begin
			n_errors++;
			results();
		end
	endtask : run

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Stimulus and checks
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		logic [19:0] v, r, e;
		logic [15:0] st, sp, so, lo, hi;
		logic [4:0] sc [3];
		logic [4:0] qy [3];
		sc = '{lrt_pkg::LRT_CMD_LEVEL_SET, lrt_pkg::LRT_CMD_AFREQ_SET, lrt_pkg::LRT_CMD_SYNC_SET};
		qy = '{lrt_pkg::LRT_CMD_LEVEL_Q, lrt_pkg::LRT_CMD_AFREQ_Q, lrt_pkg::LRT_CMD_SYNC_Q};
		seed = 32'hB7AA;
		n_errors = 0;
		checks_done = 0;
		resetn = 1'b0;
		trip_pin = 4'h0;
		chan_err_pin = 4'h0;
		vth_cross_pin = 1'b0;
		foreach (meter[i]) meter[i] = 17'h00000;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		qc(lrt_pkg::LRT_CMD_TESTING_Q, 20'h00000);
		for (int i = 0; i < 6; i++)
		begin
			cmd(sc[i % 3], 16'(i < 3));
			qc(qy[i % 3], 20'(i < 3));
		end
		for (int m = 0; m < 4; m++)
		begin
			cmd(lrt_pkg::LRT_CMD_MODE_SET, 16'(m));
			chk("load_mode", 20'(m), {18'h0, load_mode});
		end
		v = rnd();
		par(3'h6, v[15:0]);
		chk("low_level", {4'h0, v[15:0]}, {4'h0, low_level});
		par(3'h3, ~v[15:0]);
		chk("threshold_voltage", {4'h0, ~v[15:0]}, {4'h0, threshold_voltage});
		cmd(lrt_pkg::LRT_CMD_LEVEL_SET, 16'h0001);
		cmd(5'h1F, 16'h0000);
		qc(lrt_pkg::LRT_CMD_LEVEL_Q, 20'h00001);
		qc(lrt_pkg::LRT_CMD_FAULT_Q, 20'h00020);
		v = rnd();
		trip_pin = v[3:0] | 4'h1;
		chan_err_pin = v[7:4];
		repeat (5) @(negedge clk);
		trip_pin = 4'h0;
		chan_err_pin = 4'h0;
		qc(lrt_pkg::LRT_CMD_TRIP_Q, {16'h0, v[3:0] | 4'h1});
		qc(lrt_pkg::LRT_CMD_FAULT_Q, {14'h0, 2'b10, v[7:4]});
		cmd(lrt_pkg::LRT_CMD_CLR_FAULTS, 16'h0000);
		qc(lrt_pkg::LRT_CMD_FAULT_Q, 20'h00000);
		qc(lrt_pkg::LRT_CMD_TRIP_Q, 20'h00000);
		cmd(lrt_pkg::LRT_CMD_STORE, 16'h0096);
		cmd(lrt_pkg::LRT_CMD_LEVEL_SET, 16'h0000);
		cmd(lrt_pkg::LRT_CMD_RECALL, 16'h0096);
		qc(lrt_pkg::LRT_CMD_LEVEL_Q, 20'h00001);
		cmd(lrt_pkg::LRT_CMD_RECALL, 16'h0097);
		qc(lrt_pkg::LRT_CMD_FAULT_Q, 20'h00020);
		host_u.send(lrt_pkg::LRT_CMD_REMOTE, 3'h0, 16'h0000, 1'b0);
		chk("remote_mode", 20'h00000, {19'h0, remote_mode});
		cmd(lrt_pkg::LRT_CMD_REMOTE, 16'h0000);
		chk("remote_mode", 20'h00001, {19'h0, remote_mode});
		cmd(lrt_pkg::LRT_CMD_LOCAL, 16'h0000);
		chk("remote_mode", 20'h00000, {19'h0, remote_mode});
		cmd(lrt_pkg::LRT_CMD_CLR_FAULTS, 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			v = rnd();
			meter[i] = (i == 0) ? 17'h1FFFF : v[16:0];
			qc(5'(lrt_pkg::LRT_CMD_MEAS_I + i), (meter[i] > 17'h1869F) ? 20'h1869F : 20'(meter[i]));
		end
		cmd(lrt_pkg::LRT_CMD_STOP, 16'h0000);
		qc(lrt_pkg::LRT_CMD_TESTING_Q, 20'h00000);
		for (int i = 0; i < 6; i++)
		begin
			v = rnd();
			st = 16'(v[3:0]);
			sp = 16'(v[5:4]) + 16'h0001;
			so = st + 16'(v[10:6]);
			lo = 16'(v[14:11]);
			hi = st + 16'(v[19:16]);
			r = 20'(st + sp * ((so - st) / sp));
			par(3'h0, st);
			qc(lrt_pkg::LRT_CMD_PARAM_Q, {4'h0, st});
			par(3'h1, sp);
			par(3'h2, so);
			par(3'h4, lo);
			par(3'h5, hi);
			cmd(lrt_pkg::LRT_CMD_FAILEN_SET, 16'(i % 2));
			cmd(lrt_pkg::LRT_CMD_TSEL_SET, (i < 3) ? 16'h0001 : 16'h0002);
			run(n);
			chk("load_setpoint", r, {4'h0, load_setpoint});
			qc(lrt_pkg::LRT_CMD_RESULT_Q, r);
			e = 20'((i % 2 == 1) && (r < lo || r > hi));
			qc(lrt_pkg::LRT_CMD_FAIL_Q, e);
			chk("fail_indicator", e, {19'h0, fail_indicator});
		end
		cmd(lrt_pkg::LRT_CMD_TSEL_SET, 16'h0003);
		par(3'h7, 16'h0002);
		run(n);
		chk("short_len", 20'h00001, 20'(n == 8 || n == 9));
		par(3'h7, 16'h0000);
		cmd(lrt_pkg::LRT_CMD_START, 16'h0000);
		repeat (50) @(negedge clk);
		chk("short_on", 20'h00001, {19'h0, short_on});
		cmd(lrt_pkg::LRT_CMD_START, 16'h0000);
		qc(lrt_pkg::LRT_CMD_FAULT_Q, 20'h00010);
		cmd(lrt_pkg::LRT_CMD_STOP, 16'h0000);
		chk("short_on", 20'h00000, {19'h0, short_on});
		qc(lrt_pkg::LRT_CMD_TESTING_Q, 20'h00000);
		results();
	end
endmodule : load_remote_state_test_control_test
`default_nettype wire
